/* hport_params.svh */
// constants for the buffered host port handshake
// Summary of operation
// - transfer_active_n falls at first edge with select and strobe low, RAM free.
// - select and direction pass until first falling edge after grant, then latch.
// - direction sense follows dir_sense_cfg; low strap inverts read and write.
// - address and data pass until first rising edge after grant, then latch.
// - a late strobe may insert one extra clock before address latch; here a fixed synchroniser latency stands in instead.
// - extra clock delays handshake by one cycle; host holds buses longer.
// - all host inputs are asynchronous and synchronised inside.
// - read handshake follows grant by the timed delay.
// - read data driven from a rising edge before handshake falls.
// - strobe rising returns transfer_active_n and handshake_done_n high.
// - read data held briefly after strobe rises, then released.
// - contended host waits at most one internal transfer cycle.
`ifndef HPORT_PARAMS_SVH
`define HPORT_PARAMS_SVH
`define CLK_PERIOD_NS    20
`define READY_DELAY_NS   150
`define READY_CYCLES     (`READY_DELAY_NS / `CLK_PERIOD_NS)
`define RELEASE_CYCLES   2
`define MAX_WAIT_CYCLES  4
`endif

/* hport_pkg.sv */
// types for the buffered host port handshake
package hport_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_GRANT = 3'h1,
    ST_LATCH = 3'h3,
    ST_WAIT  = 3'h2,
    ST_DONE  = 3'h6,
    ST_HOLD  = 3'h7
  } port_state_t;
endpackage : hport_pkg

/* sync2.sv */
// two flip-flop synchroniser for a bundle of levels
`timescale 1ns/10ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : sync2

/* host_buffered_port_handshake.sv */
// device side handshake of the 16-bit buffered host port
`timescale 1ns/10ps
`include "hport_params.svh"
module host_buffered_port_handshake
  import hport_pkg::*;
#(
  parameter int AW = 16,
  parameter int DW = 16
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          select_n,
  input  wire logic          host_strobe_n,
  input  wire logic          mem_or_reg_sel,
  input  wire logic          direction,
  input  wire logic          dir_sense_cfg,
  input  wire logic [AW-1:0] host_addr_bus,
  input  wire logic [DW-1:0] host_data_bus_in,
  output logic      [DW-1:0] host_data_bus_out,
  output logic               host_data_bus_oe,
  output logic               transfer_active_n,
  output logic               handshake_done_n,
  input  wire logic          ram_busy,
  output logic               access_req,
  output logic               access_write,
  output logic               access_mem,
  output logic      [AW-1:0] access_addr,
  output logic      [DW-1:0] access_wdata,
  input  wire logic [DW-1:0] access_rdata
);
  localparam int SW = 5 + AW + DW;
  localparam logic [3:0] RDY_CNT = 4'(`READY_CYCLES);
  localparam logic [3:0] REL_CNT = 4'(`RELEASE_CYCLES);
  localparam logic [3:0] MAXW    = 4'(`MAX_WAIT_CYCLES);

  logic [SW-1:0] sync_q;
  logic          sel_on, stb_on, sense_s, mrs_s, dir_s;
  logic [AW-1:0] addr_s;
  logic [DW-1:0] data_s;

  // select and strobe enter inverted so the synchroniser's reset value reads as idle
  sync2 #(.W(SW)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({~select_n, ~host_strobe_n, dir_sense_cfg, mem_or_reg_sel, direction,
             host_addr_bus, host_data_bus_in}),
    .q     (sync_q)
  );
  assign {sel_on, stb_on, sense_s, mrs_s, dir_s, addr_s, data_s} = sync_q;

  // select and direction latch on the falling edge after grant
  logic mrs_neg_r, rd_neg_r, cap_neg_r;
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mrs_neg_r <= 1'b0;
      rd_neg_r  <= 1'b0;
      cap_neg_r <= 1'b0;
    end else begin
      cap_neg_r <= !transfer_active_n;
      if (!transfer_active_n && !cap_neg_r) begin
        mrs_neg_r <= mrs_s;
        rd_neg_r  <= (dir_s == sense_s);
      end
    end
  end

  typedef struct packed {
    port_state_t   st;
    logic [3:0]    cnt;
    logic [3:0]    wait_cnt;
    logic          act_n;
    logic          rdy_n;
    logic          oe;
    logic [DW-1:0] dout;
    logic          req;
    logic          wr;
    logic          mem;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } port_t;

  port_t s_r, s_nxt;

  always_comb begin
    s_nxt     = s_r;
    s_nxt.req = 1'b0;
    case (s_r.st)
      ST_IDLE: begin
        s_nxt.cnt = 4'h0;
        if (!s_r.oe)
          s_nxt.dout = '0;
        if (s_r.cnt != 4'h0 || s_r.oe) begin
          s_nxt.cnt = (s_r.cnt == 4'h0) ? 4'h0 : s_r.cnt - 4'h1;
        end
        if (sel_on && stb_on) begin
          if (!ram_busy || s_r.wait_cnt >= MAXW) begin
            s_nxt.st       = ST_GRANT;
            s_nxt.act_n    = 1'b0;
            s_nxt.wait_cnt = 4'h0;
            s_nxt.cnt      = 4'h1;
          end else begin
            s_nxt.wait_cnt = s_r.wait_cnt + 4'h1;
          end
        end
      end
      ST_GRANT: begin
        // fixed synchroniser latency stands in for the optional extra clock
        s_nxt.addr  = addr_s;
        s_nxt.wdata = data_s;
        s_nxt.st    = ST_LATCH;
      end
      ST_LATCH: begin
        s_nxt.mem = mrs_neg_r;
        s_nxt.wr  = !rd_neg_r;
        s_nxt.req = 1'b1;
        s_nxt.st  = ST_WAIT;
      end
      ST_WAIT: begin
        s_nxt.cnt = s_r.cnt + 4'h1;
        if (!s_r.wr) begin
          s_nxt.dout = access_rdata;
          s_nxt.oe   = 1'b1;
        end
        if (s_r.cnt >= RDY_CNT - 4'h1) begin
          s_nxt.rdy_n = 1'b0;
          s_nxt.st    = ST_DONE;
        end
        if (!stb_on)
          s_nxt.st = ST_DONE;
      end
      ST_DONE: begin
        if (!stb_on) begin
          s_nxt.act_n = 1'b1;
          s_nxt.rdy_n = 1'b1;
          s_nxt.cnt   = REL_CNT;
          s_nxt.st    = ST_HOLD;
        end
      end
      ST_HOLD: begin
        s_nxt.cnt = s_r.cnt - 4'h1;
        if (s_r.cnt <= 4'h1) begin
          s_nxt.oe  = 1'b0;
          s_nxt.cnt = 4'h0;
          s_nxt.st  = ST_IDLE;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r       <= '0;
      s_r.st    <= ST_IDLE;
      s_r.act_n <= 1'b1;
      s_r.rdy_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign transfer_active_n = s_r.act_n;
  assign handshake_done_n  = s_r.rdy_n;
  assign host_data_bus_out = s_r.dout;
  assign host_data_bus_oe  = s_r.oe;
  assign access_req        = s_r.req;
  assign access_write      = s_r.wr;
  assign access_mem        = s_r.mem;
  assign access_addr       = s_r.addr;
  assign access_wdata      = s_r.wdata;

  grant_needs_strobe_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(transfer_active_n) |-> $past(sel_on && stb_on))
    else $error("grant without select and strobe");

  ready_after_grant_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(handshake_done_n) |-> !transfer_active_n)
    else $error("handshake without grant");

  release_on_strobe_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.st == ST_DONE && !stb_on) |=> (transfer_active_n && handshake_done_n))
    else $error("strobe rise did not end cycle");

  read_data_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(handshake_done_n) && !access_write) |-> host_data_bus_oe)
    else $error("read data not driven before handshake");

  write_before_ready_a: assert property (@(posedge clk) disable iff (!rst_n)
    access_req |-> (handshake_done_n && !transfer_active_n))
    else $error("write not stored before handshake");

  bus_released_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(transfer_active_n) |-> ##[1:4] !host_data_bus_oe)
    else $error("data bus not released");

  wait_bounded_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.wait_cnt <= MAXW)
    else $error("host wait unbounded");

  latch_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.st == ST_WAIT) |-> $stable(access_addr))
    else $error("address changed after latch");

  idle_lines_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.st == ST_IDLE) |-> (transfer_active_n && handshake_done_n))
    else $error("handshake low while idle");

  grant_state_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(transfer_active_n) |-> (s_r.st == ST_GRANT))
    else $error("grant outside grant state");

  addr_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.st == ST_GRANT) |=> (access_addr == $past(addr_s)))
    else $error("address not latched at grant edge");

  data_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.st == ST_GRANT) |=> (access_wdata == $past(data_s)))
    else $error("data not latched at grant edge");

  req_after_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.st == ST_LATCH) |=> access_req)
    else $error("access not issued after latch");

  req_single_a: assert property (@(posedge clk) disable iff (!rst_n)
    access_req |=> !access_req)
    else $error("access request longer than one cycle");

  mode_latched_a: assert property (@(posedge clk) disable iff (!rst_n)
    access_req |-> (access_mem == mrs_neg_r))
    else $error("select not taken from falling edge latch");

  ready_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(handshake_done_n) |-> ($past(transfer_active_n, 9) && !$past(transfer_active_n, 8)))
    else $error("handshake delay wrong");

  drive_on_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    host_data_bus_oe |-> !access_write)
    else $error("data bus driven on a write");

  done_in_cycle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !handshake_done_n |-> !transfer_active_n)
    else $error("handshake low outside transfer");

  hold_ended_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.st == ST_HOLD) |-> transfer_active_n)
    else $error("transfer active during release");
endmodule : host_buffered_port_handshake

/* hport_host.sv */
// host processor model driving one transfer at a time
`timescale 1ns/10ps
module hport_host (
  input  wire logic        clk,
  input  wire logic        transfer_active_n,
  input  wire logic        handshake_done_n,
  input  wire logic [15:0] rd_bus,
  output logic             select_n,
  output logic             host_strobe_n,
  output logic             mem_or_reg_sel,
  output logic             direction,
  output logic [15:0]      host_addr_bus,
  output logic [15:0]      wr_bus
);
  initial begin
    select_n = 1'b1;
    host_strobe_n = 1'b1;
    mem_or_reg_sel = 1'b0;
    direction = 1'b0;
    host_addr_bus = 16'h0000;
    wr_bus = 16'hffff;
  end
  // called just after a falling edge; g counts edges to grant, n grant to done
  task automatic xfer(input logic m, dr, input logic [15:0] a, d,
                      output logic [15:0] q, output int g, n);
    mem_or_reg_sel = m;
    direction = dr;
    host_addr_bus = a;
    wr_bus = d;
    select_n = 1'b0;
    host_strobe_n = 1'b0;
    g = 0;
    n = 0;
    while (transfer_active_n && g < 30) begin
      @(negedge clk);
      g++;
    end
    select_n = 1'b1;
    while (handshake_done_n && n < 30) begin
      @(negedge clk);
      n++;
    end
    q = rd_bus;
    host_strobe_n = 1'b1;
    for (int i = 0; i < 30 && !handshake_done_n; i++) begin
      @(negedge clk);
    end
    // buses held to the end so an inserted extra clock is covered
    host_addr_bus = ~a;
    wr_bus = ~d;
  endtask : xfer
endmodule : hport_host

/* tb_host_buffered_port_handshake.sv */
// self-checking testbench of the buffered host port handshake
`timescale 1ns/10ps
`include "hport_params.svh"
module tb_host_buffered_port_handshake;
  logic        clk, rst_n, sel_n, stb_n, mem, dir, sense, ram_busy;
  logic        oe, act_n, done_n, req, a_wr, a_mem;
  logic [15:0] addr, wr_bus, dout, a_addr, a_wdata, bus;
  logic [33:0] cap_r;
  int          err_count, cmp_count, cyc;
  // released bus reads back as the host's inverted last word, not a held value
  assign bus = oe ? dout : wr_bus;
  host_buffered_port_handshake dut_u (.clk(clk), .rst_n(rst_n), .select_n(sel_n),
    .host_strobe_n(stb_n), .mem_or_reg_sel(mem), .direction(dir), .dir_sense_cfg(sense),
    .host_addr_bus(addr), .host_data_bus_in(bus), .host_data_bus_out(dout),
    .host_data_bus_oe(oe), .transfer_active_n(act_n), .handshake_done_n(done_n),
    .ram_busy(ram_busy), .access_req(req), .access_write(a_wr), .access_mem(a_mem),
    .access_addr(a_addr), .access_wdata(a_wdata), .access_rdata(a_addr ^ 16'h5a5a));
  hport_host host_u (.clk(clk), .transfer_active_n(act_n), .handshake_done_n(done_n),
    .rd_bus(bus), .select_n(sel_n), .host_strobe_n(stb_n), .mem_or_reg_sel(mem),
    .direction(dir), .host_addr_bus(addr), .wr_bus(wr_bus));
  always @(posedge clk) begin
    cyc++;
    if (req) cap_r <= {a_mem, a_wr, a_addr, a_wdata};
    if (cyc > 3000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic check(input logic [33:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic t_write(input logic s);
    logic [15:0] q;
    int g, n;
    sense = s;
    host_u.xfer(1'b1, ~s, 16'h0ff1 ^ {15'h0, s}, 16'hc3a5, q, g, n);
    check(cap_r, {2'b11, 16'h0ff1 ^ {15'h0, s}, 16'hc3a5});
    check(act_n, 1'b1);
  endtask : t_write
  task automatic t_read(input logic s);
    logic [15:0] q;
    int g, n;
    sense = s;
    host_u.xfer(1'b0, s, 16'hffff, 16'h1234, q, g, n);
    check(q, 16'hffff ^ 16'h5a5a);
    check(cap_r[33:32], 2'b00);
    check(34'(n), 34'(`READY_CYCLES + 1));
    check({act_n, done_n}, 2'b11);
    repeat (`RELEASE_CYCLES) @(negedge clk);
    check(oe, 1'b0);
  endtask : t_read
  task automatic t_busy();
    logic [15:0] q;
    int g0, g1, n;
    host_u.xfer(1'b1, 1'b1, 16'h0001, 16'h0002, q, g0, n);
    ram_busy = 1'b1;
    host_u.xfer(1'b1, 1'b1, 16'h0003, 16'h0004, q, g1, n);
    ram_busy = 1'b0;
    // held busy must still be granted once the wait bound runs out
    check(g1 > g0 && g1 <= g0 + `MAX_WAIT_CYCLES + 1, 1'b1);
  endtask : t_busy
  task automatic stop_test();
    $display("comparisons %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {err_count, cmp_count, cyc} = '0;
    rst_n = 1'b0;
    sense = 1'b1;
    ram_busy = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    for (int s = 0; s < 2; s++) begin
      t_write(1'(s));
      t_read(1'(s));
    end
    t_busy();
    stop_test();
  end
endmodule : tb_host_buffered_port_handshake
